// [verilog/dtp_core.sv]
`timescale 1ns/1ns
// Summary of operation
// - Clear request deasserts exactly the chosen sources lacking a fresh event that cycle
// - Disabled source never reaches the interrupt output
// - Seven separately maskable interrupt sources
// - Status readable raw or masked, same layout
// - Load write goes into counter immediately
// - Wide counter uses first half registers only
// - Edge count raises capture match at match
// - PWM output switches when counter equals match
// - Prescaler divides only in 16-bit modes
// - Prescale value is eight bits, 0 to 255
// - Prescale match extends compare to 24 bits
// - RTC enable acts only in RTC mode
// - RTC disable stops counting in RTC mode
// - Live count readable without disturbing counting
// - Programmed values read back masked to the counter width
// - Reconfiguration leaves the module disabled
// - Invert makes PWM output active low
// - Stall freezes counter during debug halt
module dtp_core import dtp_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire dtp_wide_e cfg_wide,
  input wire logic cfg_wide_up,
  input wire dtp_half_e cfg_first_mode,
  input wire logic cfg_first_up,
  input wire dtp_half_e cfg_second_mode,
  input wire logic cfg_second_up,
  input wire logic [1:0] wr_sel,
  input wire logic [31:0] wr_value,
  input wire logic wr_flag,
  input wire logic load_wr,
  input wire logic match_wr,
  input wire logic prescale_wr,
  input wire logic prescale_match_wr,
  input wire logic enable_wr,
  input wire logic disable_wr,
  input wire logic invert_wr,
  input wire logic stall_wr,
  input wire logic rtc_enable_cmd,
  input wire logic rtc_disable_cmd,
  input wire logic int_enable_wr,
  input wire logic int_disable_wr,
  input wire logic int_clear_wr,
  input wire logic [6:0] int_bits,
  input wire logic masked_select,
  input wire logic debug_halt,
  input wire logic [1:0] ccp_in,
  output logic [31:0] first_load_val,
  output logic [31:0] first_match_val,
  output logic [31:0] first_count,
  output logic [15:0] second_load_val,
  output logic [15:0] second_match_val,
  output logic [15:0] second_count,
  output logic [15:0] prescale_val,
  output logic [15:0] prescale_match_val,
  output logic [6:0] int_status,
  output logic [6:0] int_enable,
  output logic timer_irq,
  output logic [1:0] pwm_out,
  output logic [1:0] running
);

  logic [31:0] load_r [2];
  logic [31:0] match_r [2];
  logic [31:0] cnt_r [2];
  logic [7:0] pre_r [2];
  logic [7:0] prem_r [2];
  logic [7:0] pcnt_r [2];
  logic [1:0] en_r;
  logic [1:0] inv_r;
  logic [1:0] stall_r;
  logic [1:0] lvl_r;
  logic [2:0] sy_r [2];
  logic [1:0] acc_r;
  logic tmo_w [2];
  logic cmt_w [2];
  logic cev_w [2];
  logic rtm_w [2];

  dtp_wide_e wide_r;
  dtp_wide_e wide_nxt;
  logic wide_up_r;
  logic wide_up_nxt;
  dtp_half_e hmode_r [2];
  dtp_half_e hmode_nxt [2];
  logic [1:0] hup_r;
  logic [1:0] hup_nxt;
  logic rtc_run_r;
  logic rtc_run_nxt;
  logic [6:0] raw_r;
  logic [6:0] raw_nxt;
  logic [6:0] ien_r;
  logic [6:0] ien_nxt;
  logic [6:0] stat_r;
  logic [6:0] stat_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [6:0] ev_set;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_half
      logic [31:0] ln, mn, cn, msk;
      logic [7:0] pn, pmn, pc;
      logic en_n, inv_n, st_n, lv_n, ac_n, hit;
      logic [2:0] sy_n;
      logic edge_w, active, wide, up, run, tick, adv, reload;

      always_comb begin
        ln = load_r[gi];
        mn = match_r[gi];
        cn = cnt_r[gi];
        pn = pre_r[gi];
        pmn = prem_r[gi];
        pc = pcnt_r[gi];
        en_n = en_r[gi];
        inv_n = inv_r[gi];
        st_n = stall_r[gi];
        lv_n = lvl_r[gi];
        ac_n = acc_r[gi];
        tmo_w[gi] = 1'b0;
        cmt_w[gi] = 1'b0;
        cev_w[gi] = 1'b0;
        rtm_w[gi] = 1'b0;
        tick = 1'b0;
        adv = 1'b0;
        reload = 1'b0;
        hit = 1'b0;
        // Pin sampled by three flops; accept once the last two agree
        sy_n = {sy_r[gi][1:0], ccp_in[gi]};
        edge_w = 1'b0;
        if (sy_r[gi][1] == sy_r[gi][2] && sy_r[gi][2] != acc_r[gi]) begin
          ac_n = sy_r[gi][2];
          edge_w = sy_r[gi][2];
        end
        wide = (wide_r != DTP_W_PAIR);
        // Second half sits idle while the pair acts as one wide counter
        active = (gi == 0) || !wide;
        msk = (gi == 0 && wide) ? DTP_MASK32 : DTP_MASK16;
        up = wide ? (wide_up_r || wide_r == DTP_W_RTC) : hup_r[gi];
        run = en_r[gi] && active && !(stall_r[gi] && debug_halt)
          && (wide_r != DTP_W_RTC || rtc_run_r);
        if (run) begin
          if (wide) begin
            tick = 1'b1;
          end else if (hmode_r[gi] == DTP_H_CAPCOUNT && !edge_w) begin
            tick = 1'b0;
          end else begin
            adv = 1'b1;
            if (pc == pn) begin
              pc = 8'h00;
              tick = 1'b1;
            end else begin
              pc = pc + 8'h01;
            end
          end
          if (tick) begin
            adv = 1'b1;
            if (up) begin
              reload = ((cn & msk) == (ln & msk)) && wide_r != DTP_W_RTC;
              cn = reload ? 32'h00000000 : ((cn + 32'h00000001) & msk);
            end else begin
              reload = ((cn & msk) == 32'h00000000);
              cn = reload ? (ln & msk) : ((cn - 32'h00000001) & msk);
            end
          end
          // Compare taken only when the state moved, so one hit per arrival
          hit = adv && ((cn & msk) == (mn & msk)) && (wide || pc == pmn);
          if (wide_r == DTP_W_RTC) begin
            rtm_w[gi] = hit;
          end else if (wide || hmode_r[gi] == DTP_H_ONESHOT
              || hmode_r[gi] == DTP_H_PERIODIC) begin
            tmo_w[gi] = reload;
            if (reload && (wide ? wide_r == DTP_W_ONESHOT
                : hmode_r[gi] == DTP_H_ONESHOT)) begin
              en_n = 1'b0;
            end
          end else if (hmode_r[gi] == DTP_H_CAPCOUNT) begin
            cmt_w[gi] = hit;
          end else if (hmode_r[gi] == DTP_H_CAPTIME) begin
            cev_w[gi] = edge_w;
          end else begin
            if (reload) begin
              lv_n = 1'b1;
            end
            if (hit) begin
              lv_n = 1'b0;
            end
          end
        end
        if (wr_sel[gi]) begin
          if (load_wr) begin
            ln = wr_value & msk;
            cn = wr_value & msk;
            pc = 8'h00;
          end
          if (match_wr) begin
            mn = wr_value & msk;
          end
          if (prescale_wr) begin
            pn = wr_value[7:0];
          end
          if (prescale_match_wr) begin
            pmn = wr_value[7:0];
          end
          if (invert_wr) begin
            inv_n = wr_flag;
          end
          if (stall_wr) begin
            st_n = wr_flag;
          end
          if (enable_wr) begin
            en_n = 1'b1;
            lv_n = 1'b1;
          end
          if (disable_wr) begin
            en_n = 1'b0;
          end
        end
        if (cfg_wr) begin
          en_n = 1'b0;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          load_r[gi] <= DTP_RST_LOAD;
          match_r[gi] <= DTP_RST_MATCH;
          cnt_r[gi] <= DTP_RST_LOAD;
          pre_r[gi] <= DTP_RST_PRE;
          prem_r[gi] <= DTP_RST_PRE;
          pcnt_r[gi] <= DTP_RST_PRE;
          en_r[gi] <= 1'b0;
          inv_r[gi] <= 1'b0;
          stall_r[gi] <= 1'b0;
          lvl_r[gi] <= 1'b0;
          sy_r[gi] <= 3'b000;
          acc_r[gi] <= 1'b0;
        end else begin
          load_r[gi] <= ln;
          match_r[gi] <= mn;
          cnt_r[gi] <= cn;
          pre_r[gi] <= pn;
          prem_r[gi] <= pmn;
          pcnt_r[gi] <= pc;
          en_r[gi] <= en_n;
          inv_r[gi] <= inv_n;
          stall_r[gi] <= st_n;
          lvl_r[gi] <= lv_n;
          sy_r[gi] <= sy_n;
          acc_r[gi] <= ac_n;
        end
      end
    end
  endgenerate

  always_comb begin
    wide_nxt = wide_r;
    wide_up_nxt = wide_up_r;
    hmode_nxt[0] = hmode_r[0];
    hmode_nxt[1] = hmode_r[1];
    hup_nxt = hup_r;
    rtc_run_nxt = rtc_run_r;
    if (cfg_wr) begin
      wide_nxt = cfg_wide;
      wide_up_nxt = cfg_wide_up;
      hmode_nxt[0] = cfg_first_mode;
      hmode_nxt[1] = cfg_second_mode;
      hup_nxt = {cfg_second_up, cfg_first_up};
      rtc_run_nxt = 1'b0;
    end else if (rtc_enable_cmd && wide_r == DTP_W_RTC) begin
      rtc_run_nxt = 1'b1;
    end else if (rtc_disable_cmd) begin
      rtc_run_nxt = 1'b0;
    end
    ev_set = DTP_RST_IRQ;
    ev_set[DTP_IRQ_FIRST_TIMEOUT] = tmo_w[0];
    ev_set[DTP_IRQ_FIRST_CAPM] = cmt_w[0];
    ev_set[DTP_IRQ_FIRST_CAPE] = cev_w[0];
    ev_set[DTP_IRQ_RTC] = rtm_w[0];
    ev_set[DTP_IRQ_SECOND_TIMEOUT] = tmo_w[1];
    ev_set[DTP_IRQ_SECOND_CAPM] = cmt_w[1];
    ev_set[DTP_IRQ_SECOND_CAPE] = cev_w[1];
    // A fresh event in the clearing cycle survives the clear
    raw_nxt = (raw_r & ~(int_clear_wr ? int_bits : DTP_RST_IRQ)) | ev_set;
    ien_nxt = ien_r;
    if (int_enable_wr) begin
      ien_nxt = ien_nxt | int_bits;
    end
    if (int_disable_wr) begin
      ien_nxt = ien_nxt & ~int_bits;
    end
    stat_nxt = masked_select ? (raw_r & ien_r) : raw_r;
    irq_nxt = |(raw_nxt & ien_nxt);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wide_r <= DTP_W_ONESHOT;
      wide_up_r <= 1'b0;
      hmode_r[0] <= DTP_H_ONESHOT;
      hmode_r[1] <= DTP_H_ONESHOT;
      hup_r <= 2'b00;
      rtc_run_r <= 1'b0;
      raw_r <= DTP_RST_IRQ;
      ien_r <= DTP_RST_IRQ;
      stat_r <= DTP_RST_IRQ;
      irq_r <= 1'b0;
    end else begin
      wide_r <= wide_nxt;
      wide_up_r <= wide_up_nxt;
      hmode_r[0] <= hmode_nxt[0];
      hmode_r[1] <= hmode_nxt[1];
      hup_r <= hup_nxt;
      rtc_run_r <= rtc_run_nxt;
      raw_r <= raw_nxt;
      ien_r <= ien_nxt;
      stat_r <= stat_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Readback taps flops directly, so reading never disturbs counting
  assign first_load_val = load_r[0];
  assign first_match_val = match_r[0];
  assign first_count = cnt_r[0];
  assign second_load_val = load_r[1][15:0];
  assign second_match_val = match_r[1][15:0];
  assign second_count = cnt_r[1][15:0];
  assign prescale_val = {pre_r[1], pre_r[0]};
  assign prescale_match_val = {prem_r[1], prem_r[0]};
  assign int_status = stat_r;
  assign int_enable = ien_r;
  assign timer_irq = irq_r;
  // Level is high inside the active phase; invert only flips the pin sense
  assign pwm_out = lvl_r ^ inv_r;
  assign running = en_r;

endmodule

// [verilog/dtp_pkg.sv]
package dtp_pkg;

  typedef enum logic [1:0] {
    DTP_W_ONESHOT  = 2'b00,
    DTP_W_PERIODIC = 2'b01,
    DTP_W_RTC      = 2'b10,
    DTP_W_PAIR     = 2'b11
  } dtp_wide_e;

  typedef enum logic [2:0] {
    DTP_H_ONESHOT  = 3'b000,
    DTP_H_PERIODIC = 3'b001,
    DTP_H_CAPCOUNT = 3'b010,
    DTP_H_CAPTIME  = 3'b011,
    DTP_H_PWM      = 3'b100
  } dtp_half_e;

  localparam int DTP_IRQ_W = 7;
  localparam int DTP_IRQ_FIRST_TIMEOUT = 0;
  localparam int DTP_IRQ_FIRST_CAPM = 1;
  localparam int DTP_IRQ_FIRST_CAPE = 2;
  localparam int DTP_IRQ_RTC = 3;
  localparam int DTP_IRQ_SECOND_TIMEOUT = 4;
  localparam int DTP_IRQ_SECOND_CAPM = 5;
  localparam int DTP_IRQ_SECOND_CAPE = 6;

  localparam logic [31:0] DTP_MASK32 = 32'hFFFFFFFF;
  localparam logic [31:0] DTP_MASK16 = 32'h0000FFFF;
  localparam logic [31:0] DTP_RST_LOAD = 32'h00000000;
  localparam logic [31:0] DTP_RST_MATCH = 32'h00000000;
  localparam logic [7:0] DTP_RST_PRE = 8'h00;
  localparam logic [6:0] DTP_RST_IRQ = 7'h00;

endpackage

// [bench/dtp_chk_assertions.sv]
`timescale 1ns/1ns
module dtp_chk import dtp_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic load_wr,
  input wire logic prescale_wr,
  input wire logic enable_wr,
  input wire logic disable_wr,
  input wire logic int_clear_wr,
  input wire logic masked_select,
  input wire logic [1:0] wr_sel,
  input wire logic [31:0] wr_value,
  input wire logic [6:0] int_bits,
  input wire logic [31:0] first_load_val,
  input wire logic [31:0] first_count,
  input wire logic [15:0] second_load_val,
  input wire logic [15:0] second_count,
  input wire logic [15:0] prescale_val,
  input wire logic [6:0] int_status,
  input wire logic [6:0] int_enable,
  input wire logic timer_irq,
  input wire logic [1:0] pwm_out,
  input wire logic [1:0] running
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Status lags raw by a cycle, so the mask must hold across both cycles
  a_irq_raw: assert property (!masked_select && $stable(int_enable) ##1 $stable(int_enable)
    |-> $past(timer_irq) == |(int_status & int_enable)) else $error("irq differs from raw view");
  a_masked_view: assert property (masked_select && $stable(int_enable) ##1 $stable(int_enable)
    |-> (int_status & ~int_enable) == 7'h00 && $past(timer_irq) == |int_status)
    else $error("masked view wrong");
  // Nothing counts while both halves stop, so no fresh event refills a cleared bit
  a_clear_bits: assert property (int_clear_wr && running == 2'b00 ##1 !masked_select
    |=> (int_status & $past(int_bits, 2)) == 7'h00) else $error("clear missed");
  a_cfg_stop: assert property (cfg_wr |=> running == 2'b00) else $error("cfg left running");
  a_enable_run: assert property (enable_wr && wr_sel[0] && !cfg_wr && !disable_wr
    && !running[0] |=> running[0]) else $error("enable ignored");
  a_load_first: assert property (load_wr && wr_sel[0] && !cfg_wr |=> first_count == first_load_val
    && first_load_val[15:0] == $past(wr_value[15:0])) else $error("first load late");
  a_load_second: assert property (load_wr && wr_sel[1]
    |=> second_load_val == $past(wr_value[15:0])) else $error("second load wrong");
  a_pre_both: assert property (prescale_wr && wr_sel == 2'b11
    |=> prescale_val == {$past(wr_value[7:0]), $past(wr_value[7:0])}) else $error("both prescale");
  a_idle_hold: assert property (running[1] == 1'b0 && !load_wr && !cfg_wr
    |=> $stable(second_count)) else $error("idle second half moved");
  c_masked: cover property (masked_select && timer_irq);
  c_clear_live: cover property (int_clear_wr && timer_irq);
  c_pwm_fall: cover property ($fell(pwm_out[1]));
endmodule
bind dtp_core dtp_chk i_chk (.*);

// [bench/dtp_edge_src.sv]
`timescale 1ns/1ns
module dtp_edge_src (
  input wire logic sys_clk,
  output logic [1:0] ccp_in
);
  initial ccp_in = 2'b00;
  // Pins change just after core clock edges; gap sets how slowly edges arrive
  task automatic burst(input int pin, input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge sys_clk);
      ccp_in[pin] <= 1'b1;
      repeat (gap) @(posedge sys_clk);
      ccp_in[pin] <= 1'b0;
    end
  endtask
endmodule

// [bench/tb_dtp_core.sv]
`timescale 1ns/1ns
module tb_dtp_core import dtp_pkg::*; ();
  localparam int LD = 0, MT = 1, PS = 2, PM = 3, EN = 4, DS = 5, IV = 6, ST = 7;
  localparam int RE = 8, RD = 9, IE = 10, ID = 11, IC = 12, CF = 13;
  logic sys_clk, rst_n, cfg_wide_up, cfg_first_up, cfg_second_up, wr_flag;
  logic masked_select, debug_halt, timer_irq;
  wire logic cfg_wr, int_clear_wr, int_disable_wr, int_enable_wr, rtc_disable_cmd;
  wire logic rtc_enable_cmd, stall_wr, invert_wr, disable_wr, enable_wr;
  wire logic prescale_match_wr, prescale_wr, match_wr, load_wr;
  dtp_wide_e cfg_wide;
  dtp_half_e cfg_first_mode, cfg_second_mode;
  logic [13:0] stb;
  logic [1:0] wr_sel, ccp_in, pwm_out, running;
  logic [31:0] wr_value, first_load_val, first_match_val, first_count, a;
  logic [15:0] second_load_val, second_match_val, second_count, prescale_val, prescale_match_val;
  logic [6:0] int_bits, int_status, int_enable;
  int failures = 0;
  int num_checks = 0;
  assign {cfg_wr, int_clear_wr, int_disable_wr, int_enable_wr, rtc_disable_cmd, rtc_enable_cmd,
    stall_wr, invert_wr, disable_wr, enable_wr, prescale_match_wr, prescale_wr, match_wr,
    load_wr} = stb;
  dtp_core i_dut (.*);
  dtp_edge_src i_src (.*);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic nc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic put(input int k, input logic [1:0] s, input logic [31:0] v);
    @(posedge sys_clk);
    stb <= 14'h0001 << k;
    wr_sel <= s;
    wr_value <= v;
    int_bits <= v[6:0];
    wr_flag <= v[0];
    @(posedge sys_clk);
    stb <= 14'h0000;
    @(negedge sys_clk);
  endtask
  task automatic cfg(input dtp_wide_e w, input dtp_half_e f, input dtp_half_e s);
    @(posedge sys_clk);
    cfg_wide <= w;
    cfg_first_mode <= f;
    cfg_second_mode <= s;
    put(CF, 3, 0);
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    failures++;
    conclude;
  end
  initial begin
    {rst_n, cfg_wide_up, cfg_first_up, cfg_second_up, wr_flag, masked_select, debug_halt} = 0;
    {stb, wr_sel, wr_value, int_bits} = 0;
    cfg_wide = DTP_W_PAIR;
    cfg_first_mode = DTP_H_ONESHOT;
    cfg_second_mode = DTP_H_ONESHOT;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    nc(1);
    chk("rst", {int_status, int_enable, pwm_out, running, timer_irq, first_count[11:0]}, 0);
    cfg(DTP_W_PAIR, DTP_H_ONESHOT, DTP_H_ONESHOT);
    put(LD, 3, 32'h1234ABCD);
    chk("load_a", first_load_val, 32'h0000ABCD);
    chk("load_b", second_load_val, 32'h0000ABCD);
    put(MT, 3, 32'h00000055);
    chk("match", {first_match_val[15:0], second_match_val}, 32'h00550055);
    put(PS, 3, 32'h000000FF);
    chk("pre", prescale_val, 32'h0000FFFF);
    put(PM, 3, 32'h00000080);
    chk("pre_m", prescale_match_val, 32'h00008080);
    $display("readback done");
    put(PS, 1, 3);
    put(LD, 1, 100);
    put(EN, 1, 0);
    nc(2);
    a = first_count;
    nc(8);
    chk("pre_div", a - first_count, 2);
    put(LD, 1, 50);
    chk("load_now", first_count, 50);
    cfg(DTP_W_PERIODIC, DTP_H_ONESHOT, DTP_H_ONESHOT);
    chk("cfg_stop", running, 0);
    put(LD, 1, 32'h00012345);
    chk("wide_load", first_load_val, 32'h00012345);
    put(EN, 3, 0);
    nc(2);
    a = first_count;
    nc(8);
    chk("wide_step", a - first_count, 8);
    // Enable bit of the second half is set, but its count must stay frozen
    chk("b_idle", {running, second_count}, 32'h0003ABCD);
    $display("prescale done");
    cfg(DTP_W_PAIR, DTP_H_ONESHOT, DTP_H_ONESHOT);
    put(PS, 3, 0);
    put(IE, 0, 32'h7F);
    chk("int_en", int_enable, 32'h7F);
    put(LD, 3, 3);
    put(EN, 3, 0);
    nc(12);
    chk("raw_to", {running, timer_irq, int_status}, 32'h91);
    put(IC, 0, 32'h01);
    nc(1);
    chk("clr_one", int_status, 32'h10);
    put(ID, 0, 32'h10);
    nc(1);
    chk("irq_mask", {timer_irq, int_status}, 32'h10);
    @(posedge sys_clk);
    masked_select <= 1'b1;
    nc(2);
    chk("masked", int_status, 0);
    put(IE, 0, 32'h10);
    nc(1);
    chk("masked_on", {timer_irq, int_status}, 32'h90);
    put(IC, 0, 32'h7F);
    nc(1);
    chk("clr_all", {timer_irq, int_status}, 0);
    @(posedge sys_clk);
    masked_select <= 1'b0;
    $display("interrupt done");
    cfg(DTP_W_PAIR, DTP_H_CAPCOUNT, DTP_H_PWM);
    put(LD, 1, 10);
    put(MT, 1, 7);
    // Both halves need prescale match zero, or the 24-bit compare never hits
    put(PM, 3, 0);
    put(EN, 1, 0);
    i_src.burst(0, 3, 6);
    nc(10);
    chk("edge_cnt", {int_status[1], first_count[30:0]}, 32'h80000007);
    put(LD, 2, 10);
    put(MT, 2, 5);
    put(EN, 2, 0);
    for (int i = 0; i < 2; i++) begin
      put(IV, 2, i);
      repeat (24) begin
        nc(1);
        // Counts next to reload or match are skipped; only counts 7 to 9 and 1 to 3 are checked
        if (second_count inside {[7:9]})
          chk("pwm_hi", pwm_out[1], !i[0]);
        else if (second_count inside {[1:3]})
          chk("pwm_lo", pwm_out[1], i[0]);
      end
    end
    $display("capture pwm done");
    put(DS, 3, 0);
    put(RE, 0, 0);
    a = first_count;
    nc(5);
    chk("rtc_ign", first_count, a);
    cfg(DTP_W_RTC, DTP_H_ONESHOT, DTP_H_ONESHOT);
    put(EN, 1, 0);
    a = first_count;
    nc(5);
    chk("rtc_wait", first_count, a);
    put(RE, 0, 0);
    a = first_count;
    nc(5);
    chk("rtc_run", first_count - a, 5);
    put(RD, 0, 0);
    a = first_count;
    nc(5);
    chk("rtc_stop", first_count, a);
    put(MT, 1, first_count + 32'h00000002);
    put(RE, 0, 0);
    nc(4);
    chk("rtc_match", int_status[3], 1);
    put(ST, 1, 1);
    @(posedge sys_clk);
    debug_halt <= 1'b1;
    nc(2);
    a = first_count;
    nc(5);
    chk("stall", first_count, a);
    put(ST, 1, 0);
    a = first_count;
    nc(5);
    chk("no_stall", first_count - a, 5);
    @(posedge sys_clk);
    debug_halt <= 1'b0;
    $display("rtc done");
    put(IC, 0, 32'h7F);
    @(posedge sys_clk);
    cfg_first_up <= 1'b1;
    cfg(DTP_W_PAIR, DTP_H_PERIODIC, DTP_H_CAPTIME);
    put(LD, 1, 2);
    put(EN, 3, 0);
    i_src.burst(1, 1, 6);
    nc(6);
    chk("per_up", {running, int_status}, 32'h1C1);
    chk("up_range", first_count[31:2], 0);
    $display("modes done");
    conclude;
  end
endmodule
